//--- logic/modem_status_regs.sv
// Buffer pointers, interrupt flags, counters and status of the
// spread-spectrum modem, reached over a plain register port.
// Assumes all event inputs come from modem logic on clk.
// Assumes the host keeps strobes one cycle long
// and never raises both in the same cycle.
// Nothing here knows the buffer memory itself.
//
// The address-and-strobe port was left to the implementer.
module modem_status_regs #(
    parameter int COUNT_W = 16  // Width of both counters
) (
    input  wire logic       clk,
    input  wire logic       srst,
    // Register port
    // Read answer follows the strobe by a cycle
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWr,
    input  wire logic       regRd,
    output logic      [7:0] regRdData,
    // Buffer side
    // Step pulses come from host buffer moves
    input  wire logic       bufferStep,
    output logic      [7:0] bufferAddr,
    output logic      [7:0] txBase,
    output logic      [7:0] rxBase,
    // Modem events, one-cycle pulses
    // scanFound is a level, read with evScanDone
    input  wire logic       evRxTimeout,
    input  wire logic       evRxDone,
    input  wire logic       evCrcError,
    input  wire logic       evValidHeader,
    input  wire logic       evTxDone,
    input  wire logic       evScanDone,
    input  wire logic       scanFound,
    input  wire logic       evHopChange,
    input  wire logic       evRxEntry,
    // Modem levels and values
    // Packet values are read only on evRxDone
    input  wire logic       sleepMode,
    input  wire logic [7:0] rxPacketStart,
    input  wire logic [7:0] rxPacketLength,
    input  wire logic [7:0] rxPacketSnr,
    input  wire logic [2:0] rxHeaderRate,
    input  wire logic [4:0] modemStateIn,
    // Outputs to modem and pins
    // One interrupt line per flag, after masking
    output logic      [7:0] irqLines,
    output logic            headerlessSelect
);

    // =========================================
    // Elaboration checks
    // Counters are read as two bytes, so they
    // must fit in sixteen bits. Eight bits or
    // fewer would leave the high byte empty and
    // make the pair of registers meaningless.
    if (COUNT_W <= 8 || COUNT_W > modem_regs_pkg::COUNT_W_DOC)
    begin : g_bad_width
        $error("COUNT_W must lie in 9..16");
    end

    // =========================================
    // State record
    // Every register of the bank lives in one
    // record, so reset and update are written
    // once and no field can be missed.
    typedef struct packed {
        logic [7:0]         rdData;    // Read answer
        logic [7:0]         ptr;       // Buffer access pointer
        logic [7:0]         txBase;    // Transmit base
        logic [7:0]         rxBase;    // Receive base
        logic [7:0]         last;      // Last packet start
        logic [7:0]         mask;      // Interrupt mask
        logic [7:0]         flags;     // Interrupt flags
        logic [7:0]         len;       // Last payload length
        logic [COUNT_W-1:0] hdrCnt;    // Valid headers
        logic [COUNT_W-1:0] pktCnt;    // Valid packets
        logic [2:0]         rate;      // Last coding rate
        logic [4:0]         mstate;    // Modem state bits
        logic [7:0]         snr;       // Packet SNR
        logic               headless;  // Headerless select
        logic [7:0]         irq;       // Gated interrupts
    } regs_s;

    regs_s st_reg;   // Registered state
    regs_s st_next;  // Next state

    // =========================================
    // Helpers
    // Address match, used by the write decode; reads use a case on regAddr
    // Full eight-bit compare: no aliasing, so a
    // stray offset never touches a register.
    function automatic logic hit(
        input logic [7:0] addr,
        input logic [7:0] off
    );
        hit = (addr == off);
    endfunction

    // High and low byte of a counter
    // A narrow counter is widened first so the
    // high byte reads zero in its unused bits.
    function automatic logic [7:0] hiByte(
        input logic [COUNT_W-1:0] v
    );
        logic [15:0] wide;
        wide = 16'(v);
        hiByte = wide[15:8];
    endfunction

    // Low byte needs no widening
    function automatic logic [7:0] loByte(
        input logic [COUNT_W-1:0] v
    );
        loByte = v[7:0];
    endfunction

    // =========================================
    // Event vector
    // Each position holds this cycle's set request
    // Gathering the events into one vector lets a
    // single loop handle set and clear per bit.
    logic [7:0] setReq;

    always_comb
    begin
        setReq = 8'h00;
        // Fixed flag positions
        setReq[modem_regs_pkg::BIT_RECEIVE_TIMEOUT_FLAG] = evRxTimeout;
        setReq[modem_regs_pkg::BIT_RECEPTION_COMPLETE_FLAG]    = evRxDone;
        setReq[modem_regs_pkg::BIT_CRCERR]    = evCrcError;
        setReq[modem_regs_pkg::BIT_HEADER]    = evValidHeader;
        setReq[modem_regs_pkg::BIT_TRANSMIT_COMPLETE_FLAG]    = evTxDone;
        setReq[modem_regs_pkg::BIT_SCANDONE]  = evScanDone;
        setReq[modem_regs_pkg::BIT_HOP]       = evHopChange;
        // Found only rides on a scan completion
        // Found without done would be a modem fault
        setReq[modem_regs_pkg::BIT_FOUND] = evScanDone & scanFound;
    end

    // =========================================
    // Next-state logic
    // Starts from the held state, so any field
    // not touched below keeps its value. Order
    // of the blocks matters where two sources
    // meet one field: the later one wins.
    always_comb
    begin
        st_next = st_reg;

        // Buffer pointer: step after each byte
        // moved, wrapping at 8 bits
        // The host alone moves the pointer; the
        // modem reads and writes at the bases.
        if (bufferStep)
        begin
            st_next.ptr = st_reg.ptr + 8'h01;
        end

        // Software writes
        // Read-only and unmapped offsets fall
        // through every match and change nothing.
        if (regWr)
        begin
            // A host load beats a step in the same
            // cycle, so software sees what it wrote
            if (hit(regAddr, modem_regs_pkg::OFF_PTR))
            begin
                st_next.ptr = regWrData;
            end
            if (hit(regAddr, modem_regs_pkg::OFF_TXBASE))
            begin
                st_next.txBase = regWrData;
            end
            if (hit(regAddr, modem_regs_pkg::OFF_RXBASE))
            begin
                st_next.rxBase = regWrData;
            end
            if (hit(regAddr, modem_regs_pkg::OFF_MASK))
            begin
                st_next.mask = regWrData;
            end
            if (hit(regAddr, modem_regs_pkg::OFF_CONFIG))
            begin
                // Zero explicit, one headerless
                // Other bits are not stored and read
                // back as zero.
                st_next.headless =
                    regWrData[modem_regs_pkg::HEADERLESS];
            end
        end

        // Flags: write one clears, zero keeps; a
        // set in the same cycle wins
        // An event is never lost to a clear that
        // software issued for an older event.
        for (int i = 0; i < 8; i++)
        begin
            if (setReq[i])
            begin
                st_next.flags[i] = 1'b1;
            end
            else if (regWr &&
                     hit(regAddr, modem_regs_pkg::OFF_FLAGS) &&
                     regWrData[i])
            begin
                st_next.flags[i] = 1'b0;
            end
        end

        // Reception results latched at completion
        // Values held until the next completion;
        // the modem must present them in that cycle.
        if (evRxDone)
        begin
            st_next.last = rxPacketStart;
            st_next.len  = rxPacketLength;
            st_next.snr  = rxPacketSnr;
        end

        // Coding rate of the last good header
        // Only a valid header carries a rate worth
        // keeping; a failed one leaves the old rate.
        if (evValidHeader)
        begin
            st_next.rate = rxHeaderRate;
        end

        // Live modem state bits
        // One cycle of delay, no filtering; bits
        // may change between two host reads.
        st_next.mstate = modemStateIn;

        // Counters. Entry into receive restarts
        // them; sleep holds them at zero.
        // Clear beats count: an event in the cycle
        // of entry is dropped, not carried over.
        // No latch between bytes, so software must
        // read both halves while the counter rests.
        if (sleepMode || evRxEntry)
        begin
            st_next.hdrCnt = '0;
            st_next.pktCnt = '0;
        end
        else
        begin
            if (evValidHeader)
            begin
                st_next.hdrCnt =
                    st_reg.hdrCnt + COUNT_W'(1);
            end
            // A packet with a failed check is not
            // counted as valid
            // A wrap at full count is silent, as
            // for the header counter.
            if (evRxDone && !evCrcError)
            begin
                st_next.pktCnt =
                    st_reg.pktCnt + COUNT_W'(1);
            end
        end

        // Interrupt lines follow the new flags and
        // mask, so they drop with the clear
        // Using the next values costs no cycle of
        // lag between a mask write and the line.
        st_next.irq = st_next.flags & ~st_next.mask;

        // Read answer, valid the cycle after the
        // strobe only; unmapped reads give zero
        // Reads have no side effects, so a repeated
        // read of a counter or flag is harmless.
        st_next.rdData = 8'h00;
        if (regRd)
        begin
            case (regAddr)
                modem_regs_pkg::OFF_PTR:
                    st_next.rdData = st_reg.ptr;
                modem_regs_pkg::OFF_TXBASE:
                    st_next.rdData = st_reg.txBase;
                modem_regs_pkg::OFF_RXBASE:
                    st_next.rdData = st_reg.rxBase;
                modem_regs_pkg::OFF_LAST:
                    st_next.rdData = st_reg.last;
                modem_regs_pkg::OFF_MASK:
                    st_next.rdData = st_reg.mask;
                modem_regs_pkg::OFF_FLAGS:
                    st_next.rdData = st_reg.flags;
                modem_regs_pkg::OFF_LEN:
                    st_next.rdData = st_reg.len;
                // Counters read as high then low byte
                modem_regs_pkg::OFF_HDRHI:
                    st_next.rdData = hiByte(st_reg.hdrCnt);
                modem_regs_pkg::OFF_HDRLO:
                    st_next.rdData = loByte(st_reg.hdrCnt);
                modem_regs_pkg::OFF_PKTHI:
                    st_next.rdData = hiByte(st_reg.pktCnt);
                modem_regs_pkg::OFF_PKTLO:
                    st_next.rdData = loByte(st_reg.pktCnt);
                // Status: rate above the five live bits
                modem_regs_pkg::OFF_STATE:
                    st_next.rdData =
                        {st_reg.rate, st_reg.mstate};
                modem_regs_pkg::OFF_SNR:
                    st_next.rdData = st_reg.snr;
                modem_regs_pkg::OFF_CONFIG:
                    st_next.rdData = {7'h00, st_reg.headless};
                default:
                    st_next.rdData = 8'h00;
            endcase
        end
    end

    // =========================================
    // State register
    // Synchronous reset; every field has a
    // constant so outputs are defined from reset.
    // Reset wins over any event or write that
    // arrives in the same cycle.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            st_reg.rdData   <= modem_regs_pkg::RST_ZERO;
            st_reg.ptr      <= modem_regs_pkg::RST_PTR;
            st_reg.txBase   <= modem_regs_pkg::RST_TXBASE;
            st_reg.rxBase   <= modem_regs_pkg::RST_RXBASE;
            st_reg.last     <= modem_regs_pkg::RST_ZERO;
            st_reg.mask     <= modem_regs_pkg::RST_MASK;
            st_reg.flags    <= modem_regs_pkg::RST_FLAGS;
            st_reg.len      <= modem_regs_pkg::RST_ZERO;
            st_reg.hdrCnt   <= '0;
            st_reg.pktCnt   <= '0;
            st_reg.rate     <= 3'h0;
            st_reg.mstate   <= modem_regs_pkg::RST_STATE;
            st_reg.snr      <= modem_regs_pkg::RST_ZERO;
            st_reg.headless <= 1'b0;
            st_reg.irq      <= 8'h00;
        end
        else
        begin
            // Whole record in one step
            st_reg <= st_next;
        end
    end

    // =========================================
    // Outputs, straight from the state register
    // No logic after the flops, so downstream
    // timing starts at a clock edge.
    assign regRdData        = st_reg.rdData;
    assign bufferAddr       = st_reg.ptr;
    assign txBase           = st_reg.txBase;
    assign rxBase           = st_reg.rxBase;
    assign irqLines         = st_reg.irq;
    assign headerlessSelect = st_reg.headless;

endmodule

//--- logic/modem_regs_pkg.sv
// Constants shared by the modem status register bank.
// Assumes an 8-bit register address space.
package modem_regs_pkg;
    // =========================================
    // Register offsets
    localparam logic [7:0] OFF_PTR    = 8'h0d;
    localparam logic [7:0] OFF_TXBASE = 8'h0e;
    localparam logic [7:0] OFF_RXBASE = 8'h0f;
    localparam logic [7:0] OFF_LAST   = 8'h10;
    localparam logic [7:0] OFF_MASK   = 8'h11;
    localparam logic [7:0] OFF_FLAGS  = 8'h12;
    localparam logic [7:0] OFF_LEN    = 8'h13;
    localparam logic [7:0] OFF_HDRHI  = 8'h14;
    localparam logic [7:0] OFF_HDRLO  = 8'h15;
    localparam logic [7:0] OFF_PKTHI  = 8'h16;
    localparam logic [7:0] OFF_PKTLO  = 8'h17;
    localparam logic [7:0] OFF_STATE  = 8'h18;
    localparam logic [7:0] OFF_SNR    = 8'h19;
    localparam logic [7:0] OFF_CONFIG = 8'h1d;
    // =========================================
    // Reset values
    localparam logic [7:0] RST_PTR    = 8'h00;
    localparam logic [7:0] RST_TXBASE = 8'h80;
    localparam logic [7:0] RST_RXBASE = 8'h00;
    localparam logic [7:0] RST_MASK   = 8'h00;
    localparam logic [7:0] RST_FLAGS  = 8'h00;
    localparam logic [4:0] RST_STATE  = 5'h10;
    localparam logic [7:0] RST_ZERO   = 8'h00;
    // =========================================
    // Interrupt flag positions
    localparam int BIT_RECEIVE_TIMEOUT_FLAG = 7;
    localparam int BIT_RECEPTION_COMPLETE_FLAG    = 6;
    localparam int BIT_CRCERR    = 5;
    localparam int BIT_HEADER    = 4;
    localparam int BIT_TRANSMIT_COMPLETE_FLAG    = 3;
    localparam int BIT_SCANDONE  = 2;
    localparam int BIT_HOP       = 1;
    localparam int BIT_FOUND     = 0;
    // =========================================
    // Field positions and documented counter width
    localparam int RATE_LSB      = 5;
    localparam int HEADERLESS    = 0;
    localparam int COUNT_W_DOC   = 16;
endpackage

//--- tb/modem_status_regs_checker.sv
// Port checker for the modem register bank.
// Assumes one clock and a bind onto modem_status_regs.
module modem_status_regs_checker (
    input wire logic       clk,
    input wire logic       srst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic       regWr,
    input wire logic       bufferStep,
    input wire logic [7:0] bufferAddr,
    input wire logic [7:0] txBase,
    input wire logic       evScanDone,
    input wire logic       scanFound,
    input wire logic [7:0] irqLines,
    input wire logic       headerlessSelect
);
    timeunit 1ns;
    timeprecision 1ns;
    // =========================================
    // Decoded writes
    logic ptrWr;   // Pointer write, wins over a step
    logic maskWr;  // Mask write
    logic flagWr;  // Flag clear write
    assign ptrWr = regWr && regAddr == modem_regs_pkg::OFF_PTR;
    assign maskWr = regWr && regAddr == modem_regs_pkg::OFF_MASK;
    assign flagWr = regWr && regAddr == modem_regs_pkg::OFF_FLAGS;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    // =========================================
    // Properties
    property p_reset;
        $fell(srst) |-> bufferAddr == 8'h00 && txBase == 8'h80 && !irqLines;
    endproperty
    a_reset: assert property (p_reset)
        else $error("reset values wrong");
    property p_ptr_wr;
        ptrWr |=> bufferAddr == $past(regWrData);
    endproperty
    a_ptr_wr: assert property (p_ptr_wr)
        else $error("pointer write lost");
    property p_step;
        bufferStep && !ptrWr |=> bufferAddr == $past(bufferAddr) + 8'h01;
    endproperty
    a_step: assert property (p_step)
        else $error("pointer step wrong");
    property p_hold;
        !bufferStep && !ptrWr |=> $stable(bufferAddr);
    endproperty
    a_hold: assert property (p_hold)
        else $error("pointer moved alone");
    property p_mask;
        maskWr |=> (irqLines & $past(regWrData)) == 8'h00;
    endproperty
    a_mask: assert property (p_mask)
        else $error("masked line active");
    property p_keep;
        irqLines[6] && !maskWr && !(flagWr && regWrData[6]) |=> irqLines[6];
    endproperty
    a_keep: assert property (p_keep)
        else $error("flag dropped uncleared");
    property p_found;
        $rose(irqLines[0]) |-> $past(evScanDone && scanFound || maskWr);
    endproperty
    a_found: assert property (p_found)
        else $error("found line without cause");
    property p_hdr;
        regWr && regAddr == modem_regs_pkg::OFF_CONFIG
            |=> headerlessSelect == $past(regWrData[0]);
    endproperty
    a_hdr: assert property (p_hdr)
        else $error("header mode bit wrong");
endmodule

bind modem_status_regs modem_status_regs_checker modem_status_regs_checker_i (
    .clk(clk), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .bufferStep(bufferStep), .bufferAddr(bufferAddr),
    .txBase(txBase), .evScanDone(evScanDone), .scanFound(scanFound),
    .irqLines(irqLines), .headerlessSelect(headerlessSelect)
);

//--- tb/host_bus_model.sv
// Host model that drives the plain register port.
// Assumes the slave answers a read in the next cycle.
module host_bus_model (
    input  wire logic       clk,
    output logic      [7:0] regAddr,
    output logic      [7:0] regWrData,
    output logic            regWr,
    output logic            regRd
);
    timeunit 1ns;
    timeprecision 1ns;
    // Quiet bus from time zero
    initial
    begin
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
    end
    // One write cycle; inverted data after it hides stale values
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWr <= 1'b0;
        regWrData <= ~d;
    endtask
    // One read cycle; answer is checked by the bench
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        regAddr <= ~a;
    endtask
endmodule

//--- tb/modem_status_regs_tb.sv
// Self-checking bench for the modem register bank.
// Assumes host_bus_model and the bound checker are compiled first.
module modem_status_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // =========================================
    // Signals
    logic       clk, srst, bufferStep, evRxEntry, sleepMode, rdSeen;
    logic [7:0] ev, pktStart, pktLen, pktSnr, e, d, x, regRdData;
    logic [7:0] regAddr, regWrData, bufferAddr, txBase, rxBase, irqLines;
    logic       regWr, regRd, headerlessSelect;
    logic [2:0] rate;      // Header coding rate fed in
    logic [4:0] stateIn;   // Live modem state bits
    logic [7:0] q[$];      // Expected read answers
    logic [7:0] rstv[13] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h00};
    int         fail_count, checks_done, cycles, h;
    int unsigned seed = 19780;
    // =========================================
    // Instances
    host_bus_model host_bus_model_i (.clk(clk), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd));
    modem_status_regs modem_status_regs_i (.clk(clk), .srst(srst),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .bufferStep(bufferStep),
        .bufferAddr(bufferAddr), .txBase(txBase), .rxBase(rxBase),
        .evRxTimeout(ev[7]), .evRxDone(ev[6]), .evCrcError(ev[5]),
        .evValidHeader(ev[4]), .evTxDone(ev[3]), .evScanDone(ev[2] | ev[0]),
        .scanFound(ev[0]), .evHopChange(ev[1]), .evRxEntry(evRxEntry),
        .sleepMode(sleepMode), .rxPacketStart(pktStart),
        .rxPacketLength(pktLen), .rxPacketSnr(pktSnr), .rxHeaderRate(rate),
        .modemStateIn(stateIn), .irqLines(irqLines),
        .headerlessSelect(headerlessSelect));
    // =========================================
    // Helpers
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic check(input logic [7:0] x, input logic [7:0] g);
        checks_done++;
        if (g !== x)
        begin
            fail_count++;
            $display("BAD t=%0t exp=%h got=%h", $time, x, g);
        end
    endtask
    // Note the answer, then let the host read
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        q.push_back(x);
        host_bus_model_i.rd(a);
    endtask
    // One-cycle event pulse; outputs settle before return
    task automatic pulse(input logic [7:0] v);
        @(posedge clk);
        ev <= v;
        @(posedge clk);
        ev <= 8'h00;
        #1;
    endtask
    task automatic finish_test();
        $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Answer stands only in the cycle after the strobe
    always @(posedge clk)
    begin
        if (rdSeen)
            check(q.pop_front(), regRdData);
        rdSeen <= regRd;
    end
    // Hang guard, far above the expected run
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fail_count++;
            finish_test();
        end
    end
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // =========================================
    // Main sequence
    initial
    begin
        {srst, bufferStep, evRxEntry, sleepMode, rdSeen} = 5'h10;
        {ev, pktStart, pktLen, pktSnr, rate} = '0;
        stateIn = 5'h10;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 13; i++)
            rd(8'h0d + 8'(i), rstv[i]);
        rd(8'h1e, 8'h00);
        for (int i = 0; i < 5; i++)
        begin
            e = (i == 4) ? modem_regs_pkg::OFF_CONFIG
                         : 8'h0d + 8'(i == 3 ? 4 : i);
            d = rnd();
            host_bus_model_i.wr(e, d);
            x = (i == 4) ? {7'h00, d[0]} : d;
            rd(e, x);
            if (i == 1)
                check(d, txBase);
            if (i == 2)
                check(d, rxBase);
        end
        check({7'h00, d[0]}, {7'h00, headerlessSelect});
        host_bus_model_i.wr(modem_regs_pkg::OFF_CONFIG, ~d);
        rd(modem_regs_pkg::OFF_CONFIG, {7'h00, ~d[0]});
        check({7'h00, ~d[0]}, {7'h00, headerlessSelect});
        host_bus_model_i.wr(modem_regs_pkg::OFF_LEN, 8'hff);
        rd(modem_regs_pkg::OFF_LEN, 8'h00);
        host_bus_model_i.wr(modem_regs_pkg::OFF_PTR, 8'hfe);
        bufferStep <= 1'b1;
        repeat (2) @(posedge clk);
        bufferStep <= 1'b0;
        #1;
        check(8'h00, bufferAddr);
        host_bus_model_i.wr(modem_regs_pkg::OFF_MASK, 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            e = (i == 0) ? 8'h05 : 8'h01 << i;
            pulse(8'h01 << i);
            check(e, irqLines);
            rd(modem_regs_pkg::OFF_FLAGS, e);
            host_bus_model_i.wr(modem_regs_pkg::OFF_MASK, e);
            #1;
            check(8'h00, irqLines);
            host_bus_model_i.wr(modem_regs_pkg::OFF_FLAGS, ~e);
            rd(modem_regs_pkg::OFF_FLAGS, e);
            host_bus_model_i.wr(modem_regs_pkg::OFF_FLAGS, e);
            host_bus_model_i.wr(modem_regs_pkg::OFF_MASK, 8'h00);
            rd(modem_regs_pkg::OFF_FLAGS, 8'h00);
        end
        {pktStart, pktLen, pktSnr} <= {rnd(), rnd(), rnd()};
        rate <= 3'(rnd());
        stateIn <= 5'(rnd());
        pulse(8'h10);
        @(posedge clk);
        evRxEntry <= 1'b1;
        @(posedge clk);
        evRxEntry <= 1'b0;
        h = 3 + rnd() % 4;
        repeat (h) pulse(8'h10);
        pulse(8'h40);
        pulse(8'h60);
        pulse(8'h40);
        rd(modem_regs_pkg::OFF_HDRHI, 8'h00);
        rd(modem_regs_pkg::OFF_HDRLO, 8'(h));
        rd(modem_regs_pkg::OFF_PKTHI, 8'h00);
        rd(modem_regs_pkg::OFF_PKTLO, 8'h02);
        rd(modem_regs_pkg::OFF_LAST, pktStart);
        rd(modem_regs_pkg::OFF_LEN, pktLen);
        rd(modem_regs_pkg::OFF_SNR, pktSnr);
        rd(modem_regs_pkg::OFF_STATE, {rate, stateIn});
        sleepMode <= 1'b1;
        rd(modem_regs_pkg::OFF_HDRLO, 8'h00);
        rd(modem_regs_pkg::OFF_PKTLO, 8'h00);
        sleepMode <= 1'b0;
        repeat (3) @(posedge clk);
        finish_test();
    end
endmodule
